/* core/pcrs_core.sv */
`timescale 1ns/10ps
module pcrs_core
  import pcrs_pkg::*;
#(
  parameter logic [PC_W-1:0] VECTOR = INT_VECTOR
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic op_valid,
  input wire pcrs_op_type op_kind,
  input wire logic [10:0] operand,
  input wire logic [7:0] acc,
  output logic [PC_W-1:0] pc,
  output logic stack_fault_reset,
  output logic irq
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [SP_W-1:0] sp;
    logic [6:0] pc_high_latch;
    logic fault_en;
    logic [1:0] flags;
    logic [1:0] mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic fault_rst;
    logic irq;
  } pcrs_state_type;

  // Stack and shadows are not reset so that they survive resets.
  typedef struct packed {
    logic [DEPTH-1:0][PC_W-1:0] stack;
    logic [7:0][7:0] shadow;
  } pcrs_data_type;

  pcrs_state_type st_ff;
  pcrs_state_type nxt_st;
  pcrs_data_type dt_ff;
  pcrs_data_type nxt_dt;

  logic setup;
  logic wr_en;
  logic [IDX_W-1:0] idx;
  logic [PC_W-1:0] pc_inc;
  logic [PC_W-1:0] stack_top;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && st_ff.pready;
  assign idx = paddr[13:2];
  assign pc_inc = st_ff.pc + 15'h0001;
  assign stack_top = dt_ff.stack[st_ff.sp[3:0]];

  // ==========================================================
  // Next state: bus writes first, core operations override.
  always_comb begin
    logic do_push;
    logic do_pop;
    logic [PC_W-1:0] push_val;
    logic [SP_W-1:0] sp_up;
    logic [1:0] set_fl;
    logic [1:0] clr_fl;
    logic fault;
    logic [31:0] rd;
    logic hit;
    do_push = 1'b0;
    do_pop = 1'b0;
    push_val = st_ff.pc;
    set_fl = 2'b00;
    clr_fl = 2'b00;
    fault = 1'b0;
    rd = 32'h0000_0000;
    hit = 1'b1;
    nxt_st = st_ff;
    nxt_dt = dt_ff;
    nxt_st.fault_rst = 1'b0;

    // Register writes, taken in the access phase.
    if (wr_en) begin
      case (idx)
        IDX_PC_LOW: begin
          nxt_st.pc = {st_ff.pc_high_latch, pwdata[7:0]};
        end
        IDX_PC_LATCH: begin
          nxt_st.pc_high_latch = pwdata[6:0];
        end
        IDX_STACK_PTR: begin
          nxt_st.sp = pwdata[SP_W-1:0];
        end
        IDX_TOP_LOW: begin
          nxt_dt.stack[st_ff.sp[3:0]][7:0] = pwdata[7:0];
        end
        IDX_TOP_HIGH: begin
          nxt_dt.stack[st_ff.sp[3:0]][14:8] = pwdata[6:0];
        end
        IDX_IRQ_STATUS: begin
          clr_fl = pwdata[1:0];
        end
        IDX_IRQ_MASK: begin
          nxt_st.mask = pwdata[1:0];
        end
        IDX_CONFIG: begin
          nxt_st.fault_en = pwdata[BIT_FAULT_EN];
        end
        default: begin
          if (idx >= IDX_STATUS_SHD && idx <= IDX_P1H_SHD) begin
            nxt_dt.shadow[idx[2:0] - 3'h4] = pwdata[7:0];
          end
        end
      endcase
    end

    // Counter sequencing from the decoder.
    if (op_valid) begin
      case (op_kind)
        OP_STEP: begin
          nxt_st.pc = pc_inc;
        end
        OP_GOTO_CALL_ADDR: begin
          nxt_st.pc = {st_ff.pc_high_latch[6:3], operand};
        end
        OP_CALL: begin
          nxt_st.pc = {st_ff.pc_high_latch[6:3], operand};
          do_push = 1'b1;
          push_val = pc_inc;
        end
        OP_COMPUTED_CALL: begin
          nxt_st.pc = {st_ff.pc_high_latch, acc};
          do_push = 1'b1;
          push_val = pc_inc;
        end
        OP_BRW: begin
          nxt_st.pc = pc_inc + {7'h00, acc};
        end
        OP_BRA: begin
          // Sign-extend the nine-bit offset to the counter width.
          nxt_st.pc = pc_inc + {{6{operand[8]}}, operand[8:0]};
        end
        OP_RETURN, OP_RETURN_WITH_LITERAL, OP_INTERRUPT_EXIT: begin
          do_pop = 1'b1;
        end
        OP_INT_VECTOR: begin
          nxt_st.pc = VECTOR;
          do_push = 1'b1;
          push_val = st_ff.pc;
        end
        default: begin
          nxt_st.pc = nxt_st.pc;
        end
      endcase
    end

    // Stack moves; the latch is never written here.
    sp_up = st_ff.sp + 5'h01;
    if (do_push) begin
      if (st_ff.sp == SP_FULL) begin
        set_fl[BIT_OVF] = 1'b1;
        fault = st_ff.fault_en;
      end
      nxt_st.sp = sp_up;
      if (!fault) begin
        nxt_dt.stack[sp_up[3:0]] = push_val;
      end
    end
    if (do_pop) begin
      if (st_ff.sp == SP_EMPTY) begin
        set_fl[BIT_UNF] = 1'b1;
        fault = st_ff.fault_en;
      end
      nxt_st.pc = stack_top;
      nxt_st.sp = st_ff.sp - 5'h01;
    end

    // A stack fault resets the core but keeps its flags.
    if (fault) begin
      nxt_st.pc = PC_RESET;
      nxt_st.sp = SP_RESET;
      nxt_st.fault_rst = 1'b1;
    end

    // Set wins over a same-cycle clear so no event is lost.
    nxt_st.flags = (st_ff.flags & ~clr_fl) | set_fl;
    nxt_st.irq = |(nxt_st.flags & nxt_st.mask);

    // Read data is captured in the setup phase for a no-wait access.
    case (idx)
      IDX_PC_LOW: rd = {24'h000000, st_ff.pc[7:0]};
      IDX_PC_LATCH: rd = {25'h0000000, st_ff.pc_high_latch};
      IDX_STACK_PTR: rd = {27'h0000000, st_ff.sp};
      IDX_TOP_LOW: rd = {24'h000000, stack_top[7:0]};
      IDX_TOP_HIGH: rd = {25'h0000000, stack_top[14:8]};
      IDX_IRQ_STATUS: rd = {30'h00000000, st_ff.flags};
      IDX_IRQ_MASK: rd = {30'h00000000, st_ff.mask};
      IDX_CONFIG: rd = {31'h00000000, st_ff.fault_en};
      default: begin
        if (idx >= IDX_STATUS_SHD && idx <= IDX_P1H_SHD) begin
          rd = {24'h000000, dt_ff.shadow[idx[2:0] - 3'h4]};
        end else begin
          hit = 1'b0;
        end
      end
    endcase
    nxt_st.pready = setup;
    if (setup) begin
      nxt_st.prdata = pwrite ? 32'h0000_0000 : rd;
      nxt_st.pslverr = !hit;
    end else if (!psel) begin
      nxt_st.pslverr = 1'b0;
    end
  end

  // ==========================================================
  // Registers; every reset clears the counter and sets the pointer to SP_RESET.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '{pc: PC_RESET, sp: SP_RESET, pc_high_latch: 7'h00,
                 fault_en: 1'b0, flags: 2'b00, mask: 2'b00,
                 prdata: 32'h0000_0000, pready: 1'b0,
                 pslverr: 1'b0, fault_rst: 1'b0, irq: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Stack and shadows keep contents across every reset.
  always_ff @(posedge clk) begin
    dt_ff <= nxt_dt;
  end

  assign pc = st_ff.pc;
  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign stack_fault_reset = st_ff.fault_rst;
  assign irq = st_ff.irq;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_pcl_write_load: assert property (
    wr_en && idx == IDX_PC_LOW && !op_valid && !st_ff.fault_rst
    |=> pc == {$past(st_ff.pc_high_latch), $past(pwdata[7:0])})
    else $error("Low byte write did not load the full counter.");

  a_call_target: assert property (
    op_valid && op_kind == OP_CALL && !(st_ff.sp == SP_FULL
    && st_ff.fault_en) |=> pc == {$past(st_ff.pc_high_latch[6:3]),
    $past(operand)})
    else $error("Subroutine jump target wrong.");

  a_computed_call_target: assert property (
    op_valid && op_kind == OP_COMPUTED_CALL && st_ff.sp != SP_FULL
    |=> pc == {$past(st_ff.pc_high_latch), $past(acc)})
    else $error("Computed call target wrong.");

  a_brw_target: assert property (
    op_valid && op_kind == OP_BRW && !wr_en
    |=> pc == $past(st_ff.pc) + 15'h0001 + {7'h00, $past(acc)})
    else $error("Accumulator branch target wrong.");

  a_push_pop_ret: assert property (
    op_valid && op_kind == OP_CALL && st_ff.sp != SP_FULL && !wr_en
    ##1 !op_valid && !wr_en
    ##1 op_valid && op_kind == OP_RETURN && !wr_en
    |=> pc == $past(st_ff.pc, 3) + 15'h0001
        && st_ff.sp == $past(st_ff.sp, 3))
    else $error("Return did not restore the pushed address.");

  a_latch_kept: assert property (
    op_valid && !wr_en |=> st_ff.pc_high_latch == $past(st_ff.pc_high_latch))
    else $error("Stack action changed the latch.");

  a_overflow_flag: assert property (
    op_valid && op_kind == OP_CALL && st_ff.sp == SP_FULL
    |=> st_ff.flags[BIT_OVF] ##0 st_ff.flags[BIT_OVF])
    else $error("Overflow flag not set.");

  a_fault_reset: assert property (
    op_valid && op_kind == OP_RETURN && st_ff.sp == SP_EMPTY
    && st_ff.fault_en |=> stack_fault_reset && pc == PC_RESET
    && st_ff.sp == SP_RESET ##1 !stack_fault_reset)
    else $error("Underflow did not reset the core.");

  a_wrap_around: assert property (
    op_valid && op_kind == OP_CALL && st_ff.sp == SP_FULL
    && !st_ff.fault_en |=> st_ff.sp == 5'h10
    && dt_ff.stack[0] == $past(st_ff.pc) + 15'h0001)
    else $error("Seventeenth push did not overwrite entry zero.");

  a_irq_level: assert property (
    irq == |(st_ff.flags & st_ff.mask))
    else $error("Interrupt high without an unmasked flag.");

endmodule

/* core/pcrs_pkg.sv */
package pcrs_pkg;
  // ==========================================================
  // Widths and sizes
  localparam int PC_W = 15;
  localparam int SP_W = 5;
  localparam int DEPTH = 16;
  localparam int IDX_W = 12;
  // ==========================================================
  // Register indexes; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_STATUS_SHD = 12'hFE4;
  localparam logic [IDX_W-1:0] IDX_ACC_SHD = 12'hFE5;
  localparam logic [IDX_W-1:0] IDX_BANK_SHD = 12'hFE6;
  localparam logic [IDX_W-1:0] IDX_PC_HIGH_LATCH_SHD = 12'hFE7;
  localparam logic [IDX_W-1:0] IDX_P0L_SHD = 12'hFE8;
  localparam logic [IDX_W-1:0] IDX_P0H_SHD = 12'hFE9;
  localparam logic [IDX_W-1:0] IDX_P1L_SHD = 12'hFEA;
  localparam logic [IDX_W-1:0] IDX_P1H_SHD = 12'hFEB;
  localparam logic [IDX_W-1:0] IDX_STACK_PTR = 12'hFED;
  localparam logic [IDX_W-1:0] IDX_TOP_LOW = 12'hFEE;
  localparam logic [IDX_W-1:0] IDX_TOP_HIGH = 12'hFEF;
  localparam logic [IDX_W-1:0] IDX_PC_LOW = 12'hF80;
  localparam logic [IDX_W-1:0] IDX_PC_LATCH = 12'hF81;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 12'hF82;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 12'hF83;
  localparam logic [IDX_W-1:0] IDX_CONFIG = 12'hF84;
  // ==========================================================
  // Field positions and reset values
  localparam int BIT_OVF = 0;
  localparam int BIT_UNF = 1;
  localparam int BIT_FAULT_EN = 0;
  localparam logic [SP_W-1:0] SP_RESET = 5'h1F;
  localparam logic [SP_W-1:0] SP_FULL = 5'h0F;
  localparam logic [SP_W-1:0] SP_EMPTY = 5'h1F;
  localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
  localparam logic [PC_W-1:0] INT_VECTOR = 15'h0004;
  // ==========================================================
  // Core operations presented by the decoder
  typedef enum logic [3:0] {
    OP_NONE, OP_STEP, OP_GOTO_CALL_ADDR, OP_CALL, OP_COMPUTED_CALL,
    OP_BRW, OP_BRA, OP_RETURN, OP_RETURN_WITH_LITERAL, OP_INTERRUPT_EXIT, OP_INT_VECTOR
  } pcrs_op_type;
endpackage

/* verification/pcrs_decoder.sv */
`timescale 1ns/10ps
// ==========
// Decoder stand-in: issues one-cycle operation pulses.
module pcrs_decoder
  import pcrs_pkg::*;
(
  input wire logic clk,
  output logic op_valid,
  output pcrs_op_type op_kind,
  output logic [10:0] operand,
  output logic [7:0] acc
);
  // Fields start at zero; after a pulse operand and acc are inverted so a stale value can never look valid.
  initial begin
    op_valid = 1'b0;
    op_kind = OP_NONE;
    operand = 11'h000;
    acc = 8'h00;
  end
  // One pulse, then a quiet cycle so the next call never collides.
  task automatic issue(input pcrs_op_type k, input logic [10:0] o,
                       input logic [7:0] a);
    op_valid <= 1'b1;
    op_kind <= k;
    operand <= o;
    acc <= a;
    @(posedge clk);
    op_valid <= 1'b0;
    operand <= ~o;
    acc <= ~a;
    @(posedge clk);
  endtask
endmodule

/* verification/program_counter_and_return_stack_test.sv */
`timescale 1ns/10ps
module program_counter_and_return_stack_test
  import pcrs_pkg::*;
;
  // ==========
  // Signals and reference model state.
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, op_valid, sfr, irq, seen = 1'b0;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h00000000, prdata;
  pcrs_op_type op_kind;
  logic [10:0] operand;
  logic [7:0] acc, r, sh;
  logic [PC_W-1:0] pc, pc_m;
  logic [PC_W-1:0] stk [DEPTH];
  logic [SP_W-1:0] sp_m;
  logic [6:0] lat;
  logic [1:0] flg;
  logic fen;
  logic [32:0] bus_q [$];
  logic [PC_W-1:0] pc_q [$];
  int num_errors = 0, checks = 0, cyc = 0, faults = 0, faults_m = 0;
  pcrs_op_type seq [10] = '{OP_INT_VECTOR, OP_CALL, OP_COMPUTED_CALL, OP_STEP,
    OP_GOTO_CALL_ADDR, OP_BRW, OP_BRA, OP_RETURN, OP_RETURN_WITH_LITERAL, OP_INTERRUPT_EXIT};
  always #5 clk = ~clk;
  pcrs_decoder dec(.clk(clk), .op_valid(op_valid), .op_kind(op_kind),
    .operand(operand), .acc(acc));
  pcrs_core dut(.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .op_valid(op_valid),
    .op_kind(op_kind), .operand(operand), .acc(acc), .pc(pc),
    .stack_fault_reset(sfr), .irq(irq));
  // ==========
  // Comparison, reporting and the closing verdict.
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic done(input int n);
    $display("test %0d finished", n);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Watches every bus answer and the counter after each operation.
  always @(posedge clk) begin
    if ((psel & penable & pready) === 1'b1 && bus_q.size() > 0)
      cmp({pslverr, prdata}, bus_q.pop_front());
    if (seen && pc_q.size() > 0)
      cmp({18'h00000, pc}, {18'h00000, pc_q.pop_front()});
    if (sfr === 1'b1)
      faults++;
    seen <= op_valid;
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  // ==========
  // Bus master; the expected answer is queued before the request.
  task automatic xfer(input logic w, input logic [11:0] i,
                      input logic [7:0] d, input logic [32:0] e);
    bus_q.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] i, input logic [7:0] d);
    xfer(1'b0, i, d, {25'h0000000, d});
  endtask
  // Writes also update the model, so later expectations follow them.
  task automatic wr(input logic [11:0] i, input logic [7:0] d);
    case (i)
      IDX_PC_LOW: pc_m = {lat, d};
      IDX_PC_LATCH: lat = d[6:0];
      IDX_STACK_PTR: sp_m = d[4:0];
      IDX_TOP_LOW: stk[sp_m[3:0]][7:0] = d;
      IDX_TOP_HIGH: stk[sp_m[3:0]][14:8] = d[6:0];
      IDX_IRQ_STATUS: flg = flg & ~d[1:0];
      IDX_CONFIG: fen = d[0];
      default: ;
    endcase
    xfer(1'b1, i, d, 33'h000000000);
  endtask
  task automatic reset_dut();
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    pc_m = PC_RESET;
    sp_m = SP_RESET;
    lat = 7'h00;
    flg = 2'b00;
    fen = 1'b0;
  endtask
  // Reference counter and stack; a fault overrides the counter and pointer but keeps the flags.
  task automatic op(input pcrs_op_type k, input logic [10:0] o,
                    input logic [7:0] a);
    logic [PC_W-1:0] nx;
    logic fault;
    nx = pc_m + 15'h0001;
    fault = 1'b0;
    case (k)
      OP_STEP: pc_m = nx;
      OP_GOTO_CALL_ADDR: pc_m = {lat[6:3], o};
      OP_BRW: pc_m = nx + {7'h00, a};
      OP_BRA: pc_m = nx + {{6{o[8]}}, o[8:0]};
      OP_CALL, OP_COMPUTED_CALL, OP_INT_VECTOR: begin
        fault = fen && sp_m == SP_FULL;
        if (sp_m == SP_FULL) flg[BIT_OVF] = 1'b1;
        sp_m = sp_m + 5'h01;
        if (!fault) stk[sp_m[3:0]] = (k == OP_INT_VECTOR) ? pc_m : nx;
        if (k == OP_CALL) pc_m = {lat[6:3], o};
        else if (k == OP_COMPUTED_CALL) pc_m = {lat, a};
        else pc_m = INT_VECTOR;
      end
      OP_RETURN, OP_RETURN_WITH_LITERAL, OP_INTERRUPT_EXIT: begin
        fault = fen && sp_m == SP_EMPTY;
        if (sp_m == SP_EMPTY) flg[BIT_UNF] = 1'b1;
        pc_m = stk[sp_m[3:0]];
        sp_m = sp_m - 5'h01;
      end
      default: ;
    endcase
    if (fault) begin
      pc_m = PC_RESET;
      sp_m = SP_RESET;
      faults_m++;
    end
    pc_q.push_back(pc_m);
    dec.issue(k, o, a);
  endtask
  // ==========
  // Main sequence.
  initial begin
    void'($urandom(32'hC1EF));
    reset_dut();
    rd(IDX_STACK_PTR, 8'h1F);
    rd(IDX_PC_LOW, 8'h00);
    rd(IDX_CONFIG, 8'h00);
    for (int i = 0; i < 8; i++) begin
      sh = 8'($urandom());
      wr(IDX_STATUS_SHD + 12'(i), sh);
      rd(IDX_STATUS_SHD + 12'(i), sh);
    end
    done(1);
    wr(IDX_PC_LATCH, 8'($urandom()));
    r = 8'($urandom());
    wr(IDX_PC_LOW, r);
    op(OP_NONE, 11'h000, 8'h00);
    rd(IDX_PC_LOW, r);
    done(2);
    repeat (4) begin
      foreach (seq[j]) begin
        op(seq[j], 11'($urandom()), 8'($urandom()));
        if (j == 2) begin
          rd(IDX_STACK_PTR, {3'h0, sp_m});
          rd(IDX_TOP_HIGH, {1'b0, stk[sp_m[3:0]][14:8]});
          rd(IDX_PC_LATCH, {1'b0, lat});
        end
      end
    end
    rd(IDX_STACK_PTR, 8'h1F);
    // The pointer selects which entry the top pair exposes.
    wr(IDX_STACK_PTR, 8'h05);
    wr(IDX_TOP_LOW, 8'($urandom()));
    wr(IDX_TOP_HIGH, 8'($urandom()));
    op(OP_RETURN, 11'h000, 8'h00);
    rd(IDX_STACK_PTR, 8'h04);
    op(OP_CALL, 11'($urandom()), 8'h00);
    op(OP_RETURN, 11'h000, 8'h00);
    rd(IDX_STACK_PTR, 8'h04);
    done(3);
    wr(IDX_STACK_PTR, 8'h1F);
    wr(IDX_IRQ_MASK, 8'h03);
    repeat (17) op(OP_CALL, 11'($urandom()), 8'h00);
    rd(IDX_STACK_PTR, 8'h10);
    rd(IDX_TOP_LOW, stk[0][7:0]);
    rd(IDX_IRQ_STATUS, 8'h01);
    cmp({32'h00000000, irq}, 33'h000000001);
    wr(IDX_IRQ_STATUS, 8'h01);
    wr(IDX_STACK_PTR, 8'h1F);
    op(OP_RETURN, 11'h000, 8'h00);
    wr(IDX_IRQ_MASK, 8'h00);
    rd(IDX_IRQ_STATUS, 8'h02);
    cmp({32'h00000000, irq}, 33'h000000000);
    wr(IDX_IRQ_STATUS, 8'h03);
    done(4);
    wr(IDX_CONFIG, 8'h01);
    wr(IDX_STACK_PTR, 8'h0F);
    op(OP_CALL, 11'h7FF, 8'h00);
    rd(IDX_STACK_PTR, 8'h1F);
    op(OP_RETURN_WITH_LITERAL, 11'h000, 8'h00);
    rd(IDX_IRQ_STATUS, 8'h03);
    cmp(33'(faults), 33'(faults_m));
    // Unmapped places are refused; a second reset keeps the shadows.
    xfer(1'b0, 12'h000, 8'h00, {1'b1, 32'h00000000});
    xfer(1'b1, 12'hFEC, 8'hAA, {1'b1, 32'h00000000});
    reset_dut();
    rd(IDX_P1H_SHD, sh);
    rd(IDX_STACK_PTR, 8'h1F);
    op(OP_NONE, 11'h000, 8'h00);
    done(5);
    stop_test();
  end
endmodule
